/* design/lsl_cfg.svh */
// Offsets, field positions, reset values and timing figures of the status indicator block
`ifndef LSL_CFG_SVH
`define LSL_CFG_SVH

`define LSL_ADDR_W 18
`define LSL_CTL_IDX 16'h40c0
`define LSL_COM_IDX 16'h40c1
`define LSL_BLC_IDX 16'h40c2
`define LSL_STS_IDX 16'h40c3
`define LSL_CTL_ADDR ({`LSL_CTL_IDX, 2'b00})
`define LSL_COM_ADDR ({`LSL_COM_IDX, 2'b00})
`define LSL_BLC_ADDR ({`LSL_BLC_IDX, 2'b00})
`define LSL_STS_ADDR ({`LSL_STS_IDX, 2'b00})

`define LSL_B_OVR_EN 15
`define LSL_B_PAT_HI 14
`define LSL_B_PAT_LO 13
`define LSL_B_TRF_IND 12
`define LSL_B_FDX_LIT 11
`define LSL_B_HDX_LIT 10
`define LSL_B_TX_BLK 9
`define LSL_B_RX_BLK 8
`define LSL_B_TX_LIT 7
`define LSL_B_RX_LIT 6
`define LSL_B_FAST_LIT 5
`define LSL_B_SLOW_LIT 4
`define LSL_B_COL_BLK 3
`define LSL_B_FAST_BLK 2
`define LSL_B_SLOW_BLK 1
`define LSL_B_NEG_LIT 0
`define LSL_CTL_RST 16'h0311

`define LSL_B_REV_DUTY 9
`define LSL_B_COL_SEL 6
`define LSL_COM_RST 16'h0040
`define LSL_COM_MASK 16'h0240

`define LSL_BLC_SEL1_HI 11
`define LSL_BLC_SEL1_LO 8
`define LSL_BLC_SEL2_HI 7
`define LSL_BLC_SEL2_LO 4
`define LSL_BLC_RST 16'hecf0
`define LSL_BLC_MASK 16'hfff0

`define LSL_CLK_HZ 250000000
`define LSL_MS_PER_S 1000
`define LSL_ACT_LIT_MS 10

`endif

/* design/lsl_pkg.sv */
// Types shared by the status indicator block
package lsl_pkg;
	typedef enum logic [1:0] {
		LSL_PAT_DARK = 2'b00,
		LSL_PAT_LIT = 2'b01,
		LSL_PAT_BLINK1 = 2'b10,
		LSL_PAT_BLINK2 = 2'b11
	} lsl_pattern_t;
endpackage

/* design/lsl_blink_if.sv */
// Link between indicator control and blink generator
`timescale 1ns/1ps
`default_nettype none
interface lsl_blink_if;
	logic [1:0][3:0] sel;
	logic reverse;
	logic [1:0] wave;
	logic ms_tick;
	modport ctrl (output sel, output reverse, input wave, input ms_tick);
	modport gen (input sel, input reverse, output wave, output ms_tick);
endinterface
`default_nettype wire

/* design/lsl_blink_gen.sv */
// Millisecond divider and the two blink waveforms
`timescale 1ns/1ps
`default_nettype none
`include "lsl_cfg.svh"
module lsl_blink_gen #(
	parameter int MS_CYCLES = `LSL_CLK_HZ / `LSL_MS_PER_S
) (
	input wire logic pclk,
	input wire logic presetn,
	lsl_blink_if.gen bif
);
	localparam int DIV_W = $clog2(MS_CYCLES);

	// Period in ms above, dark part in ms below
	function automatic logic [23:0] blink_table(input logic [3:0] s);
		logic [23:0] t;
		t = {14'd100, 10'd50};
		case (s)
			4'h0: t = {14'd10000, 10'd600};
			4'h1: t = {14'd9400, 10'd658};
			4'h2: t = {14'd8000, 10'd640};
			4'h3: t = {14'd7400, 10'd666};
			4'h4: t = {14'd6000, 10'd660};
			4'h5: t = {14'd4000, 10'd320};
			4'h6: t = {14'd4000, 10'd320};
			4'h7: t = {14'd3000, 10'd330};
			4'h8: t = {14'd2000, 10'd320};
			4'h9: t = {14'd1000, 10'd160};
			4'ha: t = {14'd500, 10'd250};
			4'hb: t = {14'd333, 10'd166};
			4'hc: t = {14'd250, 10'd125};
			4'hd: t = {14'd166, 10'd83};
			4'he: t = {14'd125, 10'd62};
			4'hf: t = {14'd100, 10'd50};
			default: t = {14'd100, 10'd50};
		endcase
		return t;
	endfunction

	logic [DIV_W-1:0] div_reg, div_next;
	logic tick_reg, tick_next;

	always_comb
	begin
		tick_next = 1'b0;
		div_next = div_reg + DIV_W'(1);
		if (div_reg == DIV_W'(MS_CYCLES - 1))
		begin
			div_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign bif.ms_tick = tick_reg;

	for (genvar m = 0; m < 2; m++)
	begin : g_mode
		logic [13:0] cnt_reg, cnt_next;
		logic wave_reg, wave_next;
		logic [23:0] tab;

		always_comb
		begin
			tab = blink_table(bif.sel[m]);
			cnt_next = cnt_reg;
			// A shrunken period wraps on the next ms tick instead of running out the old count
			if (tick_reg)
				cnt_next = (cnt_reg >= tab[23:10] - 14'd1) ? 14'd0 : cnt_reg + 14'd1;
			if (bif.reverse)
				wave_next = cnt_reg < {4'h0, tab[9:0]};
			else
				wave_next = cnt_reg >= {4'h0, tab[9:0]};
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				cnt_reg <= 14'd0;
				wave_reg <= 1'b0;
			end
			else
			begin
				cnt_reg <= cnt_next;
				wave_reg <= wave_next;
			end
		end

		assign bif.wave[m] = wave_reg;
	end
endmodule // lsl_blink_gen
`default_nettype wire

/* design/lsl_indicator_ctrl.sv */
// Status indicator controller with its APB register file
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lsl_cfg.svh"
module lsl_indicator_ctrl #(
	parameter int MS_CYCLES = `LSL_CLK_HZ / `LSL_MS_PER_S
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LSL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_up,
	input wire logic full_duplex,
	input wire logic speed_100,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic collision,
	input wire logic phy_active,
	input wire logic aneg_link_check,
	output logic indicator
);
	logic [15:0] ctl_reg, ctl_next;
	logic [15:0] com_reg, com_next;
	logic [15:0] blc_reg, blc_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [3:0] act_cnt_reg, act_cnt_next;
	logic indicator_reg, indicator_next;
	logic blink_act_reg, blink_act_next;
	logic [15:0] sts;
	logic setup;
	logic wr;

	lsl_blink_if bif ();

	lsl_blink_gen #(
		.MS_CYCLES(MS_CYCLES)
	) u_blink (
		.pclk(pclk),
		.presetn(presetn),
		.bif(bif.gen)
	);

	assign bif.sel[0] = blc_reg[`LSL_BLC_SEL1_HI:`LSL_BLC_SEL1_LO];
	assign bif.sel[1] = blc_reg[`LSL_BLC_SEL2_HI:`LSL_BLC_SEL2_LO];
	assign bif.reverse = com_reg[`LSL_B_REV_DUTY];

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & pready_reg & ~pslverr_reg;
	assign sts = {8'h00, aneg_link_check, phy_active, speed_100, full_duplex,
		link_up, act_cnt_reg != 4'h0, blink_act_reg, indicator_reg};

	// Register file; answer always comes one cycle after setup
	always_comb
	begin
		ctl_next = ctl_reg;
		com_next = com_reg;
		blc_next = blc_reg;
		prdata_next = prdata_reg;
		pready_next = setup;
		pslverr_next = 1'b0;
		if (setup)
		begin
			case (paddr)
				`LSL_CTL_ADDR: prdata_next = {16'h0000, ctl_reg};
				`LSL_COM_ADDR: prdata_next = {16'h0000, com_reg};
				`LSL_BLC_ADDR: prdata_next = {16'h0000, blc_reg};
				`LSL_STS_ADDR: prdata_next = {16'h0000, sts};
				default:
				begin
					prdata_next = 32'h0000_0000;
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (wr)
		begin
			case (paddr)
				`LSL_CTL_ADDR: ctl_next = pwdata[15:0];
				`LSL_COM_ADDR: com_next = pwdata[15:0] & `LSL_COM_MASK;
				`LSL_BLC_ADDR: blc_next = pwdata[15:0] & `LSL_BLC_MASK;
				default: ctl_next = ctl_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_reg <= `LSL_CTL_RST;
			com_reg <= `LSL_COM_RST;
			blc_reg <= `LSL_BLC_RST;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			ctl_reg <= ctl_next;
			com_reg <= com_next;
			blc_reg <= blc_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// Indicator decision
	logic act_hit, steady, tx_blk, rx_blk, trf_blk, col_blk, fast_blk, slow_blk;
	logic blink_wave, steady_out;
	lsl_pkg::lsl_pattern_t pat;

	always_comb
	begin
		pat = lsl_pkg::lsl_pattern_t'(ctl_reg[`LSL_B_PAT_HI:`LSL_B_PAT_LO]);
		act_hit = link_up & ((ctl_reg[`LSL_B_TX_LIT] & tx_active)
			| (ctl_reg[`LSL_B_RX_LIT] & rx_active));
		act_cnt_next = act_cnt_reg;
		// One extra tick since the first one may land right away
		if (act_hit)
			act_cnt_next = 4'(`LSL_ACT_LIT_MS + 1);
		else if (bif.ms_tick && act_cnt_reg != 4'h0)
			act_cnt_next = act_cnt_reg - 4'h1;
		steady = (ctl_reg[`LSL_B_FDX_LIT] & link_up & full_duplex)
			| (ctl_reg[`LSL_B_HDX_LIT] & link_up & ~full_duplex)
			// Stretch ends with the link, so a dropped link goes dark at once
			| act_hit | (link_up & (act_cnt_reg != 4'h0))
			| (ctl_reg[`LSL_B_FAST_LIT] & link_up & speed_100)
			| (ctl_reg[`LSL_B_SLOW_LIT] & link_up & ~speed_100);
		steady_out = steady;
		if (phy_active & aneg_link_check)
			steady_out = ctl_reg[`LSL_B_NEG_LIT];
		tx_blk = ctl_reg[`LSL_B_TX_BLK] & link_up & tx_active;
		rx_blk = ctl_reg[`LSL_B_RX_BLK] & link_up & rx_active;
		trf_blk = (tx_blk | rx_blk) & (ctl_reg[`LSL_B_TRF_IND] | steady_out);
		col_blk = ctl_reg[`LSL_B_COL_BLK] & link_up & collision;
		fast_blk = ctl_reg[`LSL_B_FAST_BLK] & link_up & speed_100;
		slow_blk = ctl_reg[`LSL_B_SLOW_BLK] & link_up & ~speed_100;
		blink_act_next = trf_blk | col_blk | fast_blk | slow_blk;
		if (trf_blk)
			blink_wave = bif.wave[1];
		else if (col_blk)
			blink_wave = com_reg[`LSL_B_COL_SEL] ? bif.wave[1] : bif.wave[0];
		else
			blink_wave = bif.wave[0];
		if (ctl_reg[`LSL_B_OVR_EN])
		begin
			case (pat)
				lsl_pkg::LSL_PAT_BLINK2: indicator_next = bif.wave[1];
				lsl_pkg::LSL_PAT_BLINK1: indicator_next = bif.wave[0];
				lsl_pkg::LSL_PAT_LIT: indicator_next = 1'b1;
				default: indicator_next = 1'b0;
			endcase
		end
		else if (blink_act_next)
			indicator_next = blink_wave;
		else
			indicator_next = steady_out;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_cnt_reg <= 4'h0;
			indicator_reg <= 1'b0;
			blink_act_reg <= 1'b0;
		end
		else
		begin
			act_cnt_reg <= act_cnt_next;
			indicator_reg <= indicator_next;
			blink_act_reg <= blink_act_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign indicator = indicator_reg;
endmodule // lsl_indicator_ctrl
`default_nettype wire

/* verification/lsl_ind_checker.sv */
// Assertions on the status indicator output
`timescale 1ns/1ps
`default_nettype none
`include "lsl_cfg.svh"
module lsl_ind_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LSL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic link_up,
	input wire logic full_duplex,
	input wire logic speed_100,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic phy_active,
	input wire logic aneg_link_check,
	input wire logic indicator
);
	logic [15:0] ctl_reg;
	logic [15:0] ctl_next;
	logic calm;
	logic neg;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of the control word, taken on the same access edge as the design
	always_comb
	begin
		ctl_next = ctl_reg;
		if (psel && penable && pwrite && pready && paddr == `LSL_CTL_ADDR)
			ctl_next = pwdata[15:0];
	end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ctl_reg <= 16'h0311;
		else
			ctl_reg <= ctl_next;
	assign neg = phy_active && aneg_link_check;
	// No blink source may be live, else steady conditions do not decide
	assign calm = !ctl_reg[15] && ctl_reg[3:1] == 3'b000 && !tx_active && !rx_active && !neg;
	ovr_dark_a: assert property (ctl_reg[15:13] == 3'b100 |=> !indicator)
		else $error("override dark shows lit");
	ovr_lit_a: assert property (ctl_reg[15:13] == 3'b101 |=> indicator)
		else $error("override lit shows dark");
	fast_lit_a: assert property (calm && ctl_reg[5] && link_up && speed_100 |=> indicator)
		else $error("fast speed not lit");
	slow_lit_a: assert property (calm && ctl_reg[4] && link_up && !speed_100 |=> indicator)
		else $error("slow speed not lit");
	fdx_lit_a: assert property (calm && ctl_reg[11] && link_up && full_duplex |=> indicator)
		else $error("full duplex not lit");
	hdx_lit_a: assert property (calm && ctl_reg[10] && link_up && !full_duplex |=> indicator)
		else $error("half duplex not lit");
	neg_check_a: assert property (!ctl_reg[15] && ctl_reg[3:1] == 3'b000 && !link_up && neg
		|=> indicator == $past(ctl_reg[0]))
		else $error("negotiation check level wrong");
	idle_dark_a: assert property (!ctl_reg[15] && !link_up && !neg |=> !indicator)
		else $error("idle indicator lit");
	cover property (ctl_reg[15] && indicator);
	cover property (calm && link_up && indicator);
	cover property (neg && !indicator);
endmodule // lsl_ind_checker
`default_nettype wire

/* verification/lsl_led_model.sv */
// External indicator lamp: counts level changes of its drive
`timescale 1ns/1ps
`default_nettype none
module lsl_led_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic indicator,
	output var int edges
);
	logic last;
	always @(posedge pclk)
	begin
		if (!presetn)
			edges <= 0;
		else if (indicator !== last)
			edges <= edges + 1;
		last <= indicator;
	end
endmodule // lsl_led_model
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench of the status indicator controller
`timescale 1ns/1ps
`default_nettype none
`include "lsl_cfg.svh"
module testbench;
	localparam int MS = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`LSL_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic indicator;
	logic [7:0] pins = 8'h00;
	int bad_count = 0;
	int tests_run = 0;
	int edges;
	always #2 pclk = ~pclk;
	lsl_indicator_ctrl #(.MS_CYCLES(MS)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_up(pins[7]), .full_duplex(pins[6]), .speed_100(pins[5]), .tx_active(pins[4]),
		.rx_active(pins[3]), .collision(pins[2]), .phy_active(pins[1]),
		.aneg_link_check(pins[0]), .indicator(indicator));
	lsl_led_model led (.pclk(pclk), .presetn(presetn), .indicator(indicator), .edges(edges));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [`LSL_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Control write, then line levels, then settle past the one-edge latency
	task automatic go(input logic [15:0] c, input logic [7:0] p);
		apb(1'b1, `LSL_CTL_ADDR, {16'h0, c});
		pins <= p;
		repeat (4) @(posedge pclk);
	endtask
	task automatic t_regs;
		apb(1'b0, `LSL_CTL_ADDR, 32'h0);
		chk(rd, 32'h00000311);
		apb(1'b0, `LSL_COM_ADDR, 32'h0);
		chk(rd, 32'h00000040);
		apb(1'b0, `LSL_BLC_ADDR, 32'h0);
		chk(rd, 32'h0000ecf0);
		// Fastest rates keep the blink runs short
		apb(1'b1, `LSL_BLC_ADDR, 32'hffffffff);
		apb(1'b0, `LSL_BLC_ADDR, 32'h0);
		chk(rd, 32'h0000fff0);
		apb(1'b0, `LSL_STS_ADDR + 18'h4, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("t_regs done");
	endtask
	task automatic t_steady;
		logic [24:0] tab [9];
		tab = '{{16'h0020, 8'ha0, 1'b1}, {16'h0020, 8'h80, 1'b0}, {16'h0010, 8'h80, 1'b1},
			{16'h0800, 8'hc0, 1'b1}, {16'h0800, 8'h80, 1'b0}, {16'h0400, 8'h80, 1'b1},
			{16'h0311, 8'h03, 1'b1}, {16'h0310, 8'h03, 1'b0}, {16'h0030, 8'h20, 1'b0}};
		foreach (tab[i])
		begin
			go(tab[i][24:9], tab[i][8:1]);
			chk({31'h0, indicator}, {31'h0, tab[i][0]});
		end
		$display("t_steady done");
	endtask
	task automatic t_ovr;
		int e0;
		for (int p = 0; p < 4; p++)
		begin
			go({1'b1, p[1:0], 13'h0}, 8'ha0);
			e0 = edges;
			repeat (1000) @(posedge pclk);
			if (p < 2)
				chk({30'h0, edges == e0, indicator}, {30'h0, 1'b1, p[0]});
			else
				chk({31'h0, edges - e0 > 3}, 32'h1);
		end
		$display("t_ovr done");
	endtask
	task automatic t_blink;
		logic [24:0] tab [6];
		int e0;
		tab = '{{16'h0024, 8'ha0, 1'b1}, {16'h0012, 8'h80, 1'b1}, {16'h0018, 8'h84, 1'b1},
			{16'h0210, 8'h90, 1'b1}, {16'h0100, 8'h88, 1'b0}, {16'h1100, 8'h88, 1'b1}};
		foreach (tab[i])
		begin
			go(tab[i][24:9], tab[i][8:1]);
			e0 = edges;
			repeat (1000) @(posedge pclk);
			chk({31'h0, edges - e0 > 3}, {31'h0, tab[i][0]});
		end
		$display("t_blink done");
	endtask
	task automatic t_traffic;
		go(16'h0080, 8'h80);
		chk({31'h0, indicator}, 32'h0);
		pins <= 8'h90;
		@(posedge pclk);
		pins <= 8'h80;
		repeat (9 * MS) @(posedge pclk);
		chk({31'h0, indicator}, 32'h1);
		repeat (4 * MS) @(posedge pclk);
		chk({31'h0, indicator}, 32'h0);
		$display("t_traffic done");
	endtask
	task automatic t_rev;
		int lit;
		apb(1'b1, `LSL_COM_ADDR, 32'hffffffff);
		apb(1'b0, `LSL_COM_ADDR, 32'h0);
		chk(rd, 32'h00000240);
		// Slow mode at one blink a second; reversed it is lit for 160 ms only
		apb(1'b1, `LSL_COM_ADDR, 32'h00000200);
		apb(1'b1, `LSL_BLC_ADDR, 32'h000009f0);
		for (int k = 0; k < 2; k++)
		begin
			go(k ? 16'h0008 : 16'hc000, k ? 8'h84 : 8'h00);
			lit = 0;
			repeat (1000 * MS)
			begin
				@(posedge pclk);
				lit += indicator;
			end
			chk(lit, 32'd640);
		end
		$display("t_rev done");
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_steady;
		t_ovr;
		t_blink;
		t_traffic;
		t_rev;
		test_done;
	end
	initial
	begin
		#200000;
		bad_count++;
		test_done;
	end
endmodule // testbench
bind lsl_indicator_ctrl lsl_ind_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.link_up(link_up), .full_duplex(full_duplex), .speed_100(speed_100),
	.tx_active(tx_active), .rx_active(rx_active), .phy_active(phy_active),
	.aneg_link_check(aneg_link_check), .indicator(indicator));
`default_nettype wire
